// [pkg/pdch_map.vh]
// constants of one peripheral dma channel: register offsets, field positions, reset values
// assumes a 32-bit classic wishbone slave port and byte offsets inside one channel window
//
// Contract
// - pointer holds next memory address, advancing
// - identifier write selects handshake, direction, holding address
// - identifier width is a build parameter
// - 16-bit item counter reads remaining items
// - counter empty, reload nonzero: pointer takes reload address
// - counter empty, reload nonzero: counter takes reload
// - reload zero at empty: no more transfers
// - reload clears reload count register
// - command bit 8 clears error, resumes
// - command bit 1 disables channel
// - command bit 0 enables; command write-only
// - size field: byte, halfword, word
// - state bit 0 shows channel enabled
// - enable-set ones set mask bits
// - enable-clear ones clear mask bits
// - mask view: error 2, complete 1, reload-zero 0
// - error flag sticky until error clear
// - complete flag while counter and reload zero
// - reload-zero flag while reload count zero
// - enabled channel serves requests while work remains
`ifndef PDCH_MAP_VH
`define PDCH_MAP_VH

// ****************************************
// register byte offsets inside the window
// ****************************************
`define PDCH_OFS_MEM_POINTER     6'h00
`define PDCH_OFS_PERIPH_SELECT   6'h04
`define PDCH_OFS_ITEM_COUNTER    6'h08
`define PDCH_OFS_ADDRESS_RELOAD  6'h0c
`define PDCH_OFS_COUNT_RELOAD    6'h10
`define PDCH_OFS_CHANNEL_COMMAND 6'h14
`define PDCH_OFS_CHANNEL_MODE    6'h18
`define PDCH_OFS_CHANNEL_STATE   6'h1c
`define PDCH_OFS_IRQ_ENABLE_SET  6'h20
`define PDCH_OFS_IRQ_ENABLE_CLR  6'h24
`define PDCH_OFS_IRQ_MASK_VIEW   6'h28
`define PDCH_OFS_IRQ_STATUS      6'h2c

// ****************************************
// field positions
// ****************************************
`define PDCH_CMD_ON_BIT    0
`define PDCH_CMD_OFF_BIT   1
`define PDCH_CMD_ERROR_CLEAR_CMD_BIT  8
`define PDCH_IRQ_RCZ_BIT   0
`define PDCH_IRQ_TRC_BIT   1
`define PDCH_IRQ_TRANSFER_ERROR_FLAG_BIT  2
`define PDCH_SIZE_BYTE     2'h0
`define PDCH_SIZE_HALF     2'h1
`define PDCH_SIZE_WORD     2'h2

// ****************************************
// reset values
// ****************************************
`define PDCH_RST_POINTER   32'h0000_0000
`define PDCH_RST_COUNT     16'h0000
`define PDCH_RST_SIZE      2'h0
`define PDCH_RST_MASK      3'h0

`endif

// [hw/pdch_mover.v]
// moves one data item: a read from the source then a write to the destination
// assumes a system bus that holds a request until a one-cycle done, with err alongside done
`default_nettype none
`include "pdch_map.vh"

module pdch_mover (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        start,
  input  wire        to_periph,
  input  wire [31:0] mem_addr,
  input  wire [31:0] per_addr,
  input  wire [1:0]  size,
  output reg         bus_req,
  output reg         bus_we,
  output reg  [31:0] bus_addr,
  output reg  [31:0] bus_wdata,
  output reg  [1:0]  bus_size,
  input  wire [31:0] bus_rdata,
  input  wire        bus_done,
  input  wire        bus_err,
  output reg         done,
  output reg         mem_err,
  output wire        idle
);

  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_RD   = 2'h1;
  localparam [1:0] S_WR   = 2'h2;

  reg [1:0]  state;
  reg [31:0] dst_addr;
  reg [1:0]  dst_size;
  reg        dst_is_mem;

  // narrow items reach the peripheral with upper bits zero
  function [31:0] size_mask;
    input [1:0] sz;
    begin
      case (sz)
        `PDCH_SIZE_BYTE: size_mask = 32'h0000_00ff;
        `PDCH_SIZE_HALF: size_mask = 32'h0000_ffff;
        default:         size_mask = 32'hffff_ffff;
      endcase
    end
  endfunction

  assign idle = (state == S_IDLE);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= S_IDLE;
      bus_req    <= 1'b0;
      bus_we     <= 1'b0;
      bus_addr   <= 32'h0000_0000;
      bus_wdata  <= 32'h0000_0000;
      bus_size   <= 2'h0;
      dst_addr   <= 32'h0000_0000;
      dst_size   <= 2'h0;
      dst_is_mem <= 1'b0;
      done       <= 1'b0;
      mem_err    <= 1'b0;
    end else begin
      done    <= 1'b0;
      mem_err <= 1'b0;
      case (state)
        S_IDLE: begin
          if (start) begin
            bus_req    <= 1'b1;
            bus_we     <= 1'b0;
            bus_addr   <= to_periph ? mem_addr : per_addr;
            bus_size   <= to_periph ? size : `PDCH_SIZE_WORD;
            dst_addr   <= to_periph ? per_addr : mem_addr;
            dst_size   <= to_periph ? `PDCH_SIZE_WORD : size;
            dst_is_mem <= ~to_periph;
            state      <= S_RD;
          end
        end
        S_RD: begin
          if (bus_done) begin
            if (bus_err) begin
              // a failed peripheral read is dropped and retried later
              bus_req <= 1'b0;
              mem_err <= ~dst_is_mem;
              state   <= S_IDLE;
            end else begin
              bus_we    <= 1'b1;
              bus_addr  <= dst_addr;
              bus_size  <= dst_size;
              bus_wdata <= bus_rdata & size_mask(size);
              state     <= S_WR;
            end
          end
        end
        S_WR: begin
          if (bus_done) begin
            bus_req <= 1'b0;
            bus_we  <= 1'b0;
            done    <= ~bus_err;
            mem_err <= bus_err & dst_is_mem;
            state   <= S_IDLE;
          end
        end
        default: begin
          bus_req <= 1'b0;
          state   <= S_IDLE;
        end
      endcase
    end
  end

endmodule // pdch_mover

`default_nettype wire

// [hw/pdch_channel.v]
// one peripheral dma channel: wishbone register file, reload logic and item sequencing
// assumes peripheral request lines are levels that drop within one cycle of their ack pulse
//
// Added by the designer: the Wishbone register port.
`default_nettype none
`include "pdch_map.vh"

module pdch_channel #(
  parameter        CHANNEL    = 0,
  parameter        PID_W      = 4,
  parameter        NUM_PERIPH = 14,
  parameter        RX_COUNT   = 7,
  parameter [31:0] PER_BASE   = 32'hffff_0000,
  parameter [31:0] PER_STRIDE = 32'h0000_0100
) (
  input  wire                  CORE_CLK,
  input  wire                  RESETN,
  input  wire [5:0]            WB_ADR_I,
  input  wire [31:0]           WB_DAT_I,
  input  wire [3:0]            WB_SEL_I,
  input  wire                  WB_WE_I,
  input  wire                  WB_STB_I,
  input  wire                  WB_CYC_I,
  output reg  [31:0]           WB_DAT_O,
  output reg                   WB_ACK_O,
  input  wire [NUM_PERIPH-1:0] PERIPH_REQ,
  output reg  [NUM_PERIPH-1:0] PERIPH_ACK,
  output wire                  SYS_REQ,
  output wire                  SYS_WE,
  output wire [31:0]           SYS_ADDR,
  output wire [31:0]           SYS_WDATA,
  output wire [1:0]            SYS_SIZE,
  input  wire [31:0]           SYS_RDATA,
  input  wire                  SYS_DONE,
  input  wire                  SYS_ERR,
  output reg                   CHANNEL_IRQ
);

  localparam [PID_W-1:0] PID_RST = CHANNEL[PID_W-1:0];

  // ****************************************
  // state
  // ****************************************
  reg [31:0]      memory_pointer;
  reg [PID_W-1:0] peripheral_identifier;
  reg [15:0]      item_counter;
  reg [31:0]      address_reload;
  reg [15:0]      count_reload;
  reg [1:0]       xfer_size;
  reg             channel_on;
  reg             transfer_error_flag;
  reg [2:0]       irq_mask;
  reg             in_flight;
  reg             ack_guard;
  reg [31:0]      next_rdata;

  wire        mov_done;
  wire        mov_err;
  wire        mov_idle;

  // ****************************************
  // helpers
  // ****************************************
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  sel;
    integer i;
    begin
      wmerge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          wmerge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  function [31:0] sel_mask;
    input [3:0] sel;
    begin
      sel_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    end
  endfunction

  // reserved size 3 is treated as a word so the pointer still moves
  function [31:0] size_step;
    input [1:0] sz;
    begin
      case (sz)
        `PDCH_SIZE_BYTE: size_step = 32'h0000_0001;
        `PDCH_SIZE_HALF: size_step = 32'h0000_0002;
        default:         size_step = 32'h0000_0004;
      endcase
    end
  endfunction

  // ****************************************
  // wishbone decode
  // ****************************************
  wire        wb_req = WB_CYC_I & WB_STB_I;
  wire        wr_go  = wb_req & WB_WE_I & WB_ACK_O;
  wire [5:0]  wadr   = {WB_ADR_I[5:2], 2'b00};
  wire [31:0] wbits  = WB_DAT_I & sel_mask(WB_SEL_I);
  wire [31:0] wdat   = wmerge(next_rdata, WB_DAT_I, WB_SEL_I);

  wire wr_mar  = wr_go & (wadr == `PDCH_OFS_MEM_POINTER);
  wire wr_psr  = wr_go & (wadr == `PDCH_OFS_PERIPH_SELECT);
  wire wr_tcr  = wr_go & (wadr == `PDCH_OFS_ITEM_COUNTER);
  wire wr_address_reload = wr_go & (wadr == `PDCH_OFS_ADDRESS_RELOAD);
  wire wr_count_reload = wr_go & (wadr == `PDCH_OFS_COUNT_RELOAD);
  wire wr_cmd  = wr_go & (wadr == `PDCH_OFS_CHANNEL_COMMAND);
  wire wr_mode = wr_go & (wadr == `PDCH_OFS_CHANNEL_MODE);
  wire wr_ier  = wr_go & (wadr == `PDCH_OFS_IRQ_ENABLE_SET);
  wire wr_idr  = wr_go & (wadr == `PDCH_OFS_IRQ_ENABLE_CLR);

  wire cmd_on   = wr_cmd & wbits[`PDCH_CMD_ON_BIT];
  wire cmd_off  = wr_cmd & wbits[`PDCH_CMD_OFF_BIT];
  wire cmd_error_clear_cmd = wr_cmd & wbits[`PDCH_CMD_ERROR_CLEAR_CMD_BIT];

  // ****************************************
  // status sources
  // ****************************************
  wire reload_zero_flag       = (count_reload == 16'h0000);
  wire transfer_complete_flag = (item_counter == 16'h0000) & reload_zero_flag;
  wire [2:0] irq_status = {transfer_error_flag, transfer_complete_flag, reload_zero_flag};
  wire reload_now = (item_counter == 16'h0000) & ~reload_zero_flag;

  // ****************************************
  // peripheral selection
  // ****************************************
  // identifier picks request line, direction and holding address at once
  wire        pid_valid = (peripheral_identifier < NUM_PERIPH);
  wire        req_sel   = pid_valid & PERIPH_REQ[peripheral_identifier];
  wire        to_periph = (peripheral_identifier >= RX_COUNT);
  wire [31:0] per_addr  = PER_BASE + PER_STRIDE * {{(32-PID_W){1'b0}}, peripheral_identifier};

  // a stopped (error) or empty channel ignores requests; empty here means item counter zero, reload pending or not
  wire start = channel_on & ~transfer_error_flag & (item_counter != 16'h0000) &
               req_sel & mov_idle & ~in_flight & ~ack_guard;

  pdch_mover pdch_mover_i (
    .clk       (CORE_CLK),
    .rst_n     (RESETN),
    .start     (start),
    .to_periph (to_periph),
    .mem_addr  (memory_pointer),
    .per_addr  (per_addr),
    .size      (xfer_size),
    .bus_req   (SYS_REQ),
    .bus_we    (SYS_WE),
    .bus_addr  (SYS_ADDR),
    .bus_wdata (SYS_WDATA),
    .bus_size  (SYS_SIZE),
    .bus_rdata (SYS_RDATA),
    .bus_done  (SYS_DONE),
    .bus_err   (SYS_ERR),
    .done      (mov_done),
    .mem_err   (mov_err),
    .idle      (mov_idle)
  );

  // ****************************************
  // transfer bookkeeping
  // ****************************************
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      memory_pointer <= `PDCH_RST_POINTER;
      item_counter   <= `PDCH_RST_COUNT;
      address_reload <= `PDCH_RST_POINTER;
      count_reload   <= `PDCH_RST_COUNT;
      in_flight      <= 1'b0;
      ack_guard      <= 1'b0;
      PERIPH_ACK     <= {NUM_PERIPH{1'b0}};
    end else begin
      if (start) begin
        in_flight <= 1'b1;
      end else if (mov_idle) begin
        in_flight <= 1'b0;
      end
      // hold off one extra cycle so the served request has time to drop
      ack_guard  <= mov_done | (|PERIPH_ACK);
      PERIPH_ACK <= {NUM_PERIPH{1'b0}};
      if (mov_done & pid_valid) begin
        PERIPH_ACK[peripheral_identifier] <= 1'b1;
      end

      if (wr_mar) begin
        memory_pointer <= wmerge(memory_pointer, WB_DAT_I, WB_SEL_I);
      end else if (mov_done) begin
        memory_pointer <= memory_pointer + size_step(xfer_size);
      end else if (reload_now & ~wr_tcr) begin
        memory_pointer <= address_reload;
      end

      if (wr_tcr) begin
        item_counter <= wdat[15:0];
      end else if (mov_done) begin
        item_counter <= item_counter - 16'h0001;
      end else if (reload_now) begin
        item_counter <= count_reload;
      end

      if (wr_address_reload) begin
        address_reload <= wmerge(address_reload, WB_DAT_I, WB_SEL_I);
      end else if (reload_now & ~wr_tcr) begin
        address_reload <= 32'h0000_0000;
      end

      if (wr_count_reload) begin
        count_reload <= wdat[15:0];
      end else if (reload_now & ~wr_tcr) begin
        count_reload <= 16'h0000;
      end
    end
  end

  // ****************************************
  // control, mode and mask
  // ****************************************
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      peripheral_identifier <= PID_RST;
      xfer_size             <= `PDCH_RST_SIZE;
      channel_on            <= 1'b0;
      transfer_error_flag   <= 1'b0;
      irq_mask              <= `PDCH_RST_MASK;
      CHANNEL_IRQ           <= 1'b0;
    end else begin
      if (wr_psr) begin
        peripheral_identifier <= wdat[PID_W-1:0];
      end
      if (wr_mode) begin
        xfer_size <= wdat[1:0];
      end
      // disable wins when both command bits are written together
      if (cmd_off) begin
        channel_on <= 1'b0;
      end else if (cmd_on) begin
        channel_on <= 1'b1;
      end
      // a new error in the clearing cycle is kept
      if (mov_err) begin
        transfer_error_flag <= 1'b1;
      end else if (cmd_error_clear_cmd) begin
        transfer_error_flag <= 1'b0;
      end
      irq_mask <= (irq_mask | (wr_ier ? wbits[2:0] : 3'h0))
                  & ~(wr_idr ? wbits[2:0] : 3'h0);
      CHANNEL_IRQ <= |(irq_status & irq_mask);
    end
  end

  // ****************************************
  // read mux and wishbone answer
  // ****************************************
  always @* begin
    next_rdata = 32'h0000_0000;
    case (wadr)
      `PDCH_OFS_MEM_POINTER:    next_rdata = memory_pointer;
      `PDCH_OFS_PERIPH_SELECT:  next_rdata = {{(32-PID_W){1'b0}}, peripheral_identifier};
      `PDCH_OFS_ITEM_COUNTER:   next_rdata = {16'h0000, item_counter};
      `PDCH_OFS_ADDRESS_RELOAD: next_rdata = address_reload;
      `PDCH_OFS_COUNT_RELOAD:   next_rdata = {16'h0000, count_reload};
      `PDCH_OFS_CHANNEL_MODE:   next_rdata = {30'h0, xfer_size};
      `PDCH_OFS_CHANNEL_STATE:  next_rdata = {31'h0, channel_on};
      `PDCH_OFS_IRQ_MASK_VIEW:  next_rdata = {29'h0, irq_mask};
      `PDCH_OFS_IRQ_STATUS:     next_rdata = {29'h0, irq_status};
      default:                  next_rdata = 32'h0000_0000;
    endcase
  end

  // one wait state: ack rises the cycle after the request; unmapped reads zero
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= wb_req & ~WB_ACK_O;
      if (wb_req & ~WB_ACK_O & ~WB_WE_I) begin
        WB_DAT_O <= next_rdata;
      end
    end
  end

endmodule // pdch_channel

`default_nettype wire

// [verification/pdch_sys_model.sv]
// partner model: system bus slave with a set latency and one faulting address,
// plus peripheral request lines; assumes the channel holds a bus request until done
`default_nettype none
module pdch_sys_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        sys_req,
  input  wire logic        sys_we,
  input  wire logic [31:0] sys_addr,
  input  wire logic [31:0] sys_wdata,
  output var  logic [31:0] sys_rdata,
  output var  logic        sys_done,
  output var  logic        sys_err,
  output var  logic [13:0] periph_req,
  input  wire logic [13:0] periph_ack,
  input  wire logic [13:0] want,
  input  wire logic [7:0]  lat,
  input  wire logic [31:0] err_addr,
  output var  logic [31:0] wr_addr,
  output var  logic [31:0] wr_data,
  output var  int          n_wr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] waited;
  // ****
  // bus slave
  // ****
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_rdata  <= 32'h0;
      sys_done   <= 1'b0;
      sys_err    <= 1'b0;
      periph_req <= 14'h0;
      waited     <= 8'h0;
      wr_addr    <= 32'h0;
      wr_data    <= 32'h0;
      n_wr       <= 0;
    end else begin
      // a served line falls for one cycle before it may ask again
      periph_req <= want & ~periph_ack;
      // read data means nothing outside done, so it never rests on a stale value
      sys_rdata  <= ~sys_rdata;
      sys_done   <= 1'b0;
      sys_err    <= 1'b0;
      if (sys_req && !sys_done) begin
        waited <= waited + 8'h1;
        if (waited >= lat) begin
          waited    <= 8'h0;
          sys_done  <= 1'b1;
          sys_err   <= sys_addr == err_addr;
          sys_rdata <= ~sys_addr;
          if (sys_we && sys_addr != err_addr) begin
            wr_addr <= sys_addr;
            wr_data <= sys_wdata;
            n_wr    <= n_wr + 1;
          end
        end
      end
    end
  end
endmodule // pdch_sys_model
`default_nettype wire

// [verification/pdch_channel_chk.sv]
// assertion checker bound to the ports of one dma channel
// assumes one clock and a wishbone master that drops stb after each ack
`default_nettype none
`include "pdch_map.vh"
module pdch_channel_chk #(
  parameter NUM_PERIPH = 14
) (
  input wire logic                  CORE_CLK,
  input wire logic                  RESETN,
  input wire logic [5:0]            WB_ADR_I,
  input wire logic [31:0]           WB_DAT_I,
  input wire logic [3:0]            WB_SEL_I,
  input wire logic                  WB_WE_I,
  input wire logic                  WB_STB_I,
  input wire logic                  WB_CYC_I,
  input wire logic                  WB_ACK_O,
  input wire logic [NUM_PERIPH-1:0] PERIPH_REQ,
  input wire logic [NUM_PERIPH-1:0] PERIPH_ACK,
  input wire logic                  SYS_REQ,
  input wire logic                  SYS_WE,
  input wire logic [31:0]           SYS_ADDR,
  input wire logic                  SYS_DONE,
  input wire logic                  SYS_ERR,
  input wire logic                  CHANNEL_IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] mask;
  default clocking dc @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESETN);
  // ****
  // shadow of the interrupt mask, updated at the ack edge like the channel's own
  // ****
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      mask <= 3'h0;
    end else if (WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I && WB_SEL_I[0]) begin
      if (WB_ADR_I == `PDCH_OFS_IRQ_ENABLE_SET)
        mask <= mask | WB_DAT_I[2:0];
      if (WB_ADR_I == `PDCH_OFS_IRQ_ENABLE_CLR)
        mask <= mask & ~WB_DAT_I[2:0];
    end
  end
  a_wb_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("register ack missing or too long");
  a_req_held: assert property (SYS_REQ && !SYS_DONE |=> SYS_REQ && $stable(SYS_ADDR) && $stable(SYS_WE))
    else $error("bus request changed before done");
  a_rd_then_wr: assert property (SYS_DONE && !SYS_WE && !SYS_ERR |=> SYS_REQ && SYS_WE)
    else $error("read not followed by write");
  a_err_ends_item: assert property (SYS_DONE && SYS_ERR |=> !SYS_REQ ##1 (PERIPH_ACK == '0))
    else $error("failed access went on");
  a_ack_after_wr: assert property ($rose(|PERIPH_ACK) |-> $past(SYS_DONE, 2) && $past(SYS_WE, 2))
    else $error("peripheral ack without finished write");
  a_ack_to_req: assert property ($onehot0(PERIPH_ACK) && ((PERIPH_ACK & ~$past(PERIPH_REQ)) == '0))
    else $error("ack to a line that did not ask");
  a_start_cause: assert property ($rose(SYS_REQ) |-> $past(|PERIPH_REQ))
    else $error("bus access without a request");
  a_irq_masked: assert property ($past(mask) == 3'h0 |-> !CHANNEL_IRQ)
    else $error("interrupt with every source masked");
endmodule // pdch_channel_chk
`default_nettype wire

// [verification/test_pdch_channel.sv]
// self-checking bench for one dma channel behind a wishbone register port
// assumes the partner model stands on the system bus and the peripheral lines
`default_nettype none
`include "pdch_map.vh"
module test_pdch_channel;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, we, stb, cyc, ack, sreq, swe, sdone, serr, irq;
  logic [5:0]  adr;
  logic [3:0]  sel;
  logic [1:0]  ssize;
  logic [7:0]  lat;
  logic [13:0] preq, pack, want;
  logic [31:0] dat_i, dat_o, saddr, swdata, srdata, err_addr, wr_addr, wr_data, q;
  int          n_wr, failures, n_tests;

  pdch_channel pdch_channel_i (
    .CORE_CLK(clk), .RESETN(rst_n), .WB_ADR_I(adr), .WB_DAT_I(dat_i), .WB_SEL_I(sel),
    .WB_WE_I(we), .WB_STB_I(stb), .WB_CYC_I(cyc), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .PERIPH_REQ(preq), .PERIPH_ACK(pack), .SYS_REQ(sreq), .SYS_WE(swe), .SYS_ADDR(saddr),
    .SYS_WDATA(swdata), .SYS_SIZE(ssize), .SYS_RDATA(srdata), .SYS_DONE(sdone),
    .SYS_ERR(serr), .CHANNEL_IRQ(irq));
  pdch_sys_model pdch_sys_model_i (
    .clk(clk), .rst_n(rst_n), .sys_req(sreq), .sys_we(swe), .sys_addr(saddr), .sys_wdata(swdata),
    .sys_rdata(srdata), .sys_done(sdone), .sys_err(serr), .periph_req(preq), .periph_ack(pack),
    .want(want), .lat(lat), .err_addr(err_addr), .wr_addr(wr_addr), .wr_data(wr_data), .n_wr(n_wr));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ****
  // helpers
  // ****
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (failures == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // one classic cycle; the slave's latency is not assumed, only bounded
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    sel   <= 4'hf;
    we    <= w;
    adr   <= a;
    dat_i <= d;
    for (i = 0; i < 20 && ack !== 1'b1; i++)
      @(posedge clk);
    if (ack !== 1'b1) begin
      check("ack", ack, 1'b1);
      give_verdict();
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input string what, input logic [5:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(what, q, exp);
  endtask
  task automatic wait_wr(input int n);
    int i;
    for (i = 0; i < 600 && n_wr != n; i++)
      @(posedge clk);
    check("items", n_wr, n);
    if (n_wr != n)
      give_verdict();
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset();
    rd("ptr", `PDCH_OFS_MEM_POINTER, 32'h0);
    rd("select", `PDCH_OFS_PERIPH_SELECT, 32'h0);
    rd("count", `PDCH_OFS_ITEM_COUNTER, 32'h0);
    rd("reload addr", `PDCH_OFS_ADDRESS_RELOAD, 32'h0);
    rd("reload count", `PDCH_OFS_COUNT_RELOAD, 32'h0);
    wb(1'b1, `PDCH_OFS_CHANNEL_STATE, 32'h1);
    rd("state", `PDCH_OFS_CHANNEL_STATE, 32'h0);
    wb(1'b1, `PDCH_OFS_IRQ_MASK_VIEW, 32'h7);
    rd("mask", `PDCH_OFS_IRQ_MASK_VIEW, 32'h0);
    rd("command", `PDCH_OFS_CHANNEL_COMMAND, 32'h0);
    rd("status", `PDCH_OFS_IRQ_STATUS, 32'h3);
    rd("unmapped", 6'h30, 32'h0);
  endtask
  task automatic t_mask();
    wb(1'b1, `PDCH_OFS_IRQ_ENABLE_SET, 32'h1);
    repeat (2) @(posedge clk);
    check("irq on", irq, 1'b1);
    wb(1'b1, `PDCH_OFS_IRQ_ENABLE_CLR, 32'h1);
    repeat (2) @(posedge clk);
    check("irq off", irq, 1'b0);
    wb(1'b1, `PDCH_OFS_IRQ_ENABLE_SET, 32'h6);
    wb(1'b1, `PDCH_OFS_IRQ_ENABLE_SET, 32'h0);
    rd("mask set", `PDCH_OFS_IRQ_MASK_VIEW, 32'h6);
    wb(1'b1, `PDCH_OFS_IRQ_ENABLE_CLR, 32'h2);
    wb(1'b1, `PDCH_OFS_IRQ_ENABLE_CLR, 32'h0);
    rd("mask clear", `PDCH_OFS_IRQ_MASK_VIEW, 32'h4);
    check("irq error only", irq, 1'b0);
  endtask
  // receive into memory, halfwords, with one reload behind the first buffer
  task automatic t_rx();
    lat <= 8'd20;
    wb(1'b1, `PDCH_OFS_PERIPH_SELECT, 32'h2);
    wb(1'b1, `PDCH_OFS_CHANNEL_MODE, 32'h1);
    wb(1'b1, `PDCH_OFS_MEM_POINTER, 32'h100);
    wb(1'b1, `PDCH_OFS_ITEM_COUNTER, 32'h2);
    wb(1'b1, `PDCH_OFS_ADDRESS_RELOAD, 32'h200);
    wb(1'b1, `PDCH_OFS_COUNT_RELOAD, 32'h1);
    want <= 14'h0004;
    wb(1'b1, `PDCH_OFS_CHANNEL_COMMAND, 32'h1);
    rd("state on", `PDCH_OFS_CHANNEL_STATE, 32'h1);
    wait_wr(1);
    rd("count mid", `PDCH_OFS_ITEM_COUNTER, 32'h1);
    rd("ptr mid", `PDCH_OFS_MEM_POINTER, 32'h102);
    wait_wr(2);
    @(posedge clk);  // the reload lands one edge after the counter runs out
    rd("count reloaded", `PDCH_OFS_ITEM_COUNTER, 32'h1);
    rd("ptr reloaded", `PDCH_OFS_MEM_POINTER, 32'h200);
    rd("reload cleared", `PDCH_OFS_COUNT_RELOAD, 32'h0);
    rd("status reload", `PDCH_OFS_IRQ_STATUS, 32'h1);
    wait_wr(3);
    check("wr addr", wr_addr, 32'h200);
    check("wr data", wr_data, 32'h0000fdff);
    check("wr size", ssize, 32'h1);
    repeat (60) @(posedge clk);
    check("no more items", n_wr, 3);
    rd("ptr end", `PDCH_OFS_MEM_POINTER, 32'h202);
    rd("status done", `PDCH_OFS_IRQ_STATUS, 32'h3);
  endtask
  // transmit from memory, bytes
  task automatic t_tx();
    want <= 14'h0;
    lat <= 8'd0;
    wb(1'b1, `PDCH_OFS_PERIPH_SELECT, 32'h9);
    wb(1'b1, `PDCH_OFS_CHANNEL_MODE, 32'h0);
    wb(1'b1, `PDCH_OFS_MEM_POINTER, 32'h500);
    wb(1'b1, `PDCH_OFS_ITEM_COUNTER, 32'h1);
    want <= 14'h0200;
    wait_wr(4);
    check("tx addr", wr_addr, 32'hffff0900);
    check("tx data", wr_data, 32'h000000ff);
    check("tx size", ssize, 32'h2);
    rd("ptr byte", `PDCH_OFS_MEM_POINTER, 32'h501);
  endtask
  // a faulting memory write stops the channel until the error is cleared
  task automatic t_err();
    int i;
    want <= 14'h0;
    err_addr <= 32'h300;
    wb(1'b1, `PDCH_OFS_PERIPH_SELECT, 32'h2);
    wb(1'b1, `PDCH_OFS_CHANNEL_MODE, 32'h2);
    wb(1'b1, `PDCH_OFS_MEM_POINTER, 32'h300);
    wb(1'b1, `PDCH_OFS_ITEM_COUNTER, 32'h2);
    want <= 14'h0004;
    q = 32'h0;
    for (i = 0; i < 40 && q[2] !== 1'b1; i++)
      wb(1'b0, `PDCH_OFS_IRQ_STATUS, 32'h0);
    check("error flag", q, 32'h5);
    check("irq error", irq, 1'b1);
    rd("count kept", `PDCH_OFS_ITEM_COUNTER, 32'h2);
    wb(1'b1, `PDCH_OFS_CHANNEL_COMMAND, 32'h0);
    repeat (40) @(posedge clk);
    check("stopped", n_wr, 4);
    rd("error sticky", `PDCH_OFS_IRQ_STATUS, 32'h5);
    wb(1'b1, `PDCH_OFS_MEM_POINTER, 32'h400);
    wb(1'b1, `PDCH_OFS_CHANNEL_COMMAND, 32'h100);
    wait_wr(6);
    check("resumed", wr_addr, 32'h404);
    rd("error cleared", `PDCH_OFS_IRQ_STATUS, 32'h3);
    check("irq gone", irq, 1'b0);
  endtask
  task automatic t_off();
    wb(1'b1, `PDCH_OFS_CHANNEL_COMMAND, 32'h2);
    rd("state off", `PDCH_OFS_CHANNEL_STATE, 32'h0);
    wb(1'b1, `PDCH_OFS_ITEM_COUNTER, 32'h1);
    wb(1'b1, `PDCH_OFS_CHANNEL_COMMAND, 32'h0);
    rd("zero command", `PDCH_OFS_CHANNEL_STATE, 32'h0);
    wb(1'b1, `PDCH_OFS_CHANNEL_COMMAND, 32'h3);
    repeat (60) @(posedge clk);
    check("held off", n_wr, 6);
    rd("both bits", `PDCH_OFS_CHANNEL_STATE, 32'h0);
    wb(1'b1, `PDCH_OFS_CHANNEL_COMMAND, 32'h1);
    wait_wr(7);
    rd("state back", `PDCH_OFS_CHANNEL_STATE, 32'h1);
  endtask

  initial begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 6'h0;
    dat_i = 32'h0;
    want = 14'h0;
    lat = 8'h0;
    err_addr = 32'hffff_fff0;
    failures = 0;
    n_tests = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_mask();
    t_rx();
    t_tx();
    t_err();
    t_off();
    give_verdict();
  end
endmodule // test_pdch_channel

bind pdch_channel pdch_channel_chk #(.NUM_PERIPH(NUM_PERIPH)) pdch_channel_chk_i (
  .CORE_CLK(CORE_CLK), .RESETN(RESETN), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I),
  .WB_SEL_I(WB_SEL_I), .WB_WE_I(WB_WE_I), .WB_STB_I(WB_STB_I), .WB_CYC_I(WB_CYC_I),
  .WB_ACK_O(WB_ACK_O), .PERIPH_REQ(PERIPH_REQ), .PERIPH_ACK(PERIPH_ACK), .SYS_REQ(SYS_REQ),
  .SYS_WE(SYS_WE), .SYS_ADDR(SYS_ADDR), .SYS_DONE(SYS_DONE), .SYS_ERR(SYS_ERR),
  .CHANNEL_IRQ(CHANNEL_IRQ));
`default_nettype wire
